// ===== rtl/clsc_top.sv
`timescale 1ns/10ps
`include "clsc_params.svh"
module clsc_top #(
  parameter int FLUSH_NS = `CLSC_FLUSH_NS,
  parameter int SHIFT_CYC = `CLSC_SHIFT_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic exposureGate,
  input wire logic pixelFlushPulse,
  input wire logic frameClearPulse,
  input wire logic powerDownPin,
  input wire logic [1:0] addressSelectA,
  input wire logic [1:0] addressSelectB,
  input wire logic readActive,
  input wire logic frameTaken,
  input wire logic tempValid,
  input wire clsc_pkg::clsc_temp_t tempLeft,
  input wire clsc_pkg::clsc_temp_t tempRight,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  output logic pixelFlushActive,
  output logic storeClear,
  output logic readoutAbort,
  output logic frameAvailable,
  output logic shifting,
  output logic exposing,
  output logic powerDownActive,
  output logic [7:0] acqConf,
  output logic [7:0] bwConf,
  output logic [7:0] miscConf,
  output logic [7:0] oscTrim,
  output logic [7:0] gbwSel,
  output logic [7:0] tempConf
);
  import clsc_pkg::*;

  localparam int FLUSH_CYC = (FLUSH_NS + `CLSC_CLK_NS - 1) / `CLSC_CLK_NS;
  localparam logic [15:0] FLUSH_LD = 16'(FLUSH_CYC);

  // ********************************************************
  // Pin synchronisers
  // ********************************************************
  logic [7:0] pinS1, pinS2, pinS3;
  logic gate, gateRise, pixRise, clrRise, pdLvl;
  logic [1:0] selA, selB;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinS1 <= 8'h00;
      pinS2 <= 8'h00;
      pinS3 <= 8'h00;
    end else begin
      pinS1 <= {exposureGate, pixelFlushPulse, frameClearPulse,
                powerDownPin, addressSelectA, addressSelectB};
      pinS2 <= pinS1;
      pinS3 <= pinS2;
    end
  end

  assign gate = pinS2[7];
  assign gateRise = pinS2[7] && !pinS3[7];
  assign pixRise = pinS2[6] && !pinS3[6];
  assign clrRise = pinS2[5] && !pinS3[5];
  assign pdLvl = pinS2[4];
  assign selA = pinS2[3:2];
  assign selB = pinS2[1:0];

  // ********************************************************
  // Serial slave
  // ********************************************************
  clsc_reg_if rif();

  // Open drain: only ever pulls low
  assign sdaOut = 1'b0;

  clsc_i2c_slave u_slave (
    .clk(clk),
    .arst_n(arst_n),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOe(sdaOe),
    .rif(rif)
  );

  // ********************************************************
  // Acquisition sequencer
  // ********************************************************
  clsc_seq_e st, stNext;
  logic [15:0] seqCnt_reg, seqCnt_next, flushCnt_reg, flushCnt_next;
  logic [2:0] frameCnt_reg, frameCnt_next;
  logic abort_next, clr_next, flushAct_next;

  always_comb begin
    stNext = st;
    seqCnt_next = (seqCnt_reg != 16'h0) ? seqCnt_reg - 16'h1 : 16'h0;
    flushCnt_next = (flushCnt_reg != 16'h0) ? flushCnt_reg - 16'h1 : 16'h0;
    frameCnt_next = frameCnt_reg;
    abort_next = 1'b0;
    clr_next = 1'b0;
    if (frameTaken && frameCnt_reg != 3'h0) begin
      frameCnt_next = frameCnt_reg - 3'h1;
    end
    if (pixRise && !gate && st == SEQ_IDLE) begin
      flushCnt_next = FLUSH_LD;
    end
    if (clrRise && st != SEQ_SHIFT) begin
      frameCnt_next = 3'h0;
      abort_next = 1'b1;
      clr_next = 1'b1;
    end
    unique case (st)
      SEQ_IDLE: begin
        if (pdLvl && !readActive) begin
          stNext = SEQ_PWRDN;
          frameCnt_next = 3'h0;
        end else if (gateRise) begin
          if (flushCnt_reg != 16'h0 || frameCnt_reg == `CLSC_MAX_FRAMES) begin
            stNext = SEQ_IGNORE;
          end else begin
            stNext = SEQ_EXPFLUSH;
            seqCnt_next = FLUSH_LD - 16'h1;
          end
        end
      end
      SEQ_EXPFLUSH: begin
        if (seqCnt_reg == 16'h0) begin
          stNext = SEQ_EXPOSE;
        end
      end
      SEQ_EXPOSE: begin
        if (!gate) begin
          stNext = SEQ_SHIFT;
          seqCnt_next = 16'(SHIFT_CYC - 1);
        end
      end
      SEQ_SHIFT: begin
        if (seqCnt_reg == 16'h0) begin
          stNext = SEQ_IDLE;
          frameCnt_next = frameCnt_next + 3'h1;
        end
      end
      SEQ_IGNORE: begin
        if (!gate) begin
          stNext = SEQ_IDLE;
        end
      end
      SEQ_PWRDN: begin
        frameCnt_next = 3'h0;
        if (!pdLvl) begin
          stNext = SEQ_WAKE;
          seqCnt_next = FLUSH_LD - 16'h1;
          clr_next = 1'b1;
        end
      end
      SEQ_WAKE: begin
        if (seqCnt_reg == 16'h0) begin
          stNext = SEQ_IDLE;
        end
      end
    endcase
    if (rif.softRst) begin
      stNext = SEQ_IDLE;
      seqCnt_next = 16'h0;
      flushCnt_next = 16'h0;
      frameCnt_next = 3'h0;
      abort_next = 1'b0;
      clr_next = 1'b0;
    end
    flushAct_next = flushCnt_next != 16'h0 || stNext == SEQ_EXPFLUSH ||
                    stNext == SEQ_WAKE;
  end

  // no path to the sampled stage
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= SEQ_IDLE;
      seqCnt_reg <= 16'h0;
      flushCnt_reg <= 16'h0;
      frameCnt_reg <= 3'h0;
      readoutAbort <= 1'b0;
      storeClear <= 1'b0;
      pixelFlushActive <= 1'b0;
      frameAvailable <= 1'b0;
      shifting <= 1'b0;
      exposing <= 1'b0;
      powerDownActive <= 1'b0;
    end else begin
      st <= stNext;
      seqCnt_reg <= seqCnt_next;
      flushCnt_reg <= flushCnt_next;
      frameCnt_reg <= frameCnt_next;
      readoutAbort <= abort_next;
      storeClear <= clr_next;
      pixelFlushActive <= flushAct_next;
      frameAvailable <= frameCnt_next != 3'h0;
      shifting <= stNext == SEQ_SHIFT;
      exposing <= stNext == SEQ_EXPOSE;
      powerDownActive <= stNext == SEQ_PWRDN;
    end
  end

  // ********************************************************
  // Register file
  // ********************************************************
  logic [7:0] ptr_reg, ptr_next;
  logic [7:0] acq_next, bw_next, misc_next, trim_next, gbw_next, tcf_next;
  clsc_temp_t tempL_reg, tempL_next, tempR_reg, tempR_next;
  logic [3:0] rdMask_reg, rdMask_next;
  logic [6:0] devAddr_reg, devAddr_next;
  logic [1:0] addrLoad_reg, addrLoad_next;
  logic [6:0] pinAddr;

  function automatic logic [1:0] tern(input logic [1:0] code);
    tern = (code == 2'h0) ? 2'h0 : (code == 2'h1) ? 2'h1 : 2'h3;
  endfunction

  assign pinAddr = {`CLSC_ADDR_PREFIX, tern(selB), tern(selA)};
  assign rif.devAddr = devAddr_reg;

  always_comb begin
    ptr_next = ptr_reg;
    acq_next = acqConf;
    bw_next = bwConf;
    misc_next = miscConf;
    trim_next = oscTrim;
    gbw_next = gbwSel;
    tcf_next = tempConf;
    rdMask_next = rdMask_reg;
    devAddr_next = devAddr_reg;
    addrLoad_next = addrLoad_reg;
    tempL_next = tempL_reg;
    tempR_next = tempR_reg;
    if (rif.ptrLoad) begin
      ptr_next = rif.wdata;
    end
    if (rif.wrStb) begin
      ptr_next = ptr_reg + 8'h1;
      case (ptr_reg)
        `CLSC_REG_ACQ: acq_next = rif.wdata;
        `CLSC_REG_BW: bw_next = rif.wdata;
        `CLSC_REG_MISC: misc_next = rif.wdata;
        `CLSC_REG_TRIM: trim_next = rif.wdata;
        `CLSC_REG_GBW: gbw_next = rif.wdata;
        `CLSC_REG_TEMP_CONF: tcf_next = rif.wdata;
        default: begin
        end
      endcase
    end
    if (rif.rdStb) begin
      ptr_next = ptr_reg + 8'h1;
      if (ptr_reg[7:2] == `CLSC_REG_TEMP_BASE) begin
        rdMask_next[ptr_reg[1:0]] = 1'b1;
      end
    end
    if (rdMask_next == 4'hf) begin
      rdMask_next = 4'h0;
    end
    // Frozen once any byte of the set is read, until all four are read
    if (tempValid && rdMask_reg == 4'h0) begin
      tempL_next = tempLeft;
      tempR_next = tempRight;
    end
    if (addrLoad_reg != 2'h0 || rif.resample) begin
      devAddr_next = pinAddr;
      addrLoad_next = (addrLoad_reg != 2'h0) ? addrLoad_reg - 2'h1 : 2'h0;
    end
    if (rif.softRst) begin
      ptr_next = 8'h00;
      acq_next = `CLSC_CONF_RST;
      bw_next = `CLSC_CONF_RST;
      misc_next = `CLSC_CONF_RST;
      trim_next = `CLSC_TRIM_RST;
      gbw_next = `CLSC_TRIM_RST;
      tcf_next = `CLSC_CONF_RST;
      rdMask_next = 4'h0;
      addrLoad_next = 2'h3;
    end
  end

  // Strap reload spans sync latency after release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_reg <= 8'h00;
      acqConf <= `CLSC_CONF_RST;
      bwConf <= `CLSC_CONF_RST;
      miscConf <= `CLSC_CONF_RST;
      oscTrim <= `CLSC_TRIM_RST;
      gbwSel <= `CLSC_TRIM_RST;
      tempConf <= `CLSC_CONF_RST;
      tempL_reg <= 12'h000;
      tempR_reg <= 12'h000;
      rdMask_reg <= 4'h0;
      devAddr_reg <= 7'h00;
      addrLoad_reg <= 2'h3;
    end else begin
      ptr_reg <= ptr_next;
      acqConf <= acq_next;
      bwConf <= bw_next;
      miscConf <= misc_next;
      oscTrim <= trim_next;
      gbwSel <= gbw_next;
      tempConf <= tcf_next;
      tempL_reg <= tempL_next;
      tempR_reg <= tempR_next;
      rdMask_reg <= rdMask_next;
      devAddr_reg <= devAddr_next;
      addrLoad_reg <= addrLoad_next;
    end
  end

  always_comb begin
    case (ptr_reg)
      `CLSC_REG_ACQ, `CLSC_REG_ACQ_EFF: rif.rdata = acqConf;
      `CLSC_REG_BW, `CLSC_REG_BW_EFF: rif.rdata = bwConf;
      `CLSC_REG_MISC: rif.rdata = miscConf;
      `CLSC_REG_TRIM: rif.rdata = oscTrim;
      `CLSC_REG_GBW: rif.rdata = gbwSel;
      {`CLSC_REG_TEMP_BASE, 2'h0}: rif.rdata = tempL_reg[7:0];
      {`CLSC_REG_TEMP_BASE, 2'h1}: rif.rdata = {4'h0, tempL_reg[11:8]};
      {`CLSC_REG_TEMP_BASE, 2'h2}: rif.rdata = tempR_reg[7:0];
      {`CLSC_REG_TEMP_BASE, 2'h3}: rif.rdata = {4'h0, tempR_reg[11:8]};
      `CLSC_REG_TEMP_CONF: rif.rdata = tempConf;
      default: rif.rdata = 8'h00;
    endcase
  end

  // ********************************************************
  // Checks
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  shift_length_a: assert property (
    $rose(shifting) |-> shifting[*8] ##18 (!shifting && frameAvailable))
    else $error("shift length wrong");
  flush_window_a: assert property (
    (st == SEQ_IDLE && gateRise && flushCnt_reg != 16'h0 && !pdLvl &&
     !rif.softRst) |=> st == SEQ_IGNORE)
    else $error("gate accepted in flush window");
  pix_ignore_a: assert property (
    (pixRise && (gate || st == SEQ_SHIFT)) |=> flushCnt_reg != FLUSH_LD)
    else $error("flush edge not ignored");
  clear_abort_a: assert property (
    (clrRise && st != SEQ_SHIFT && !rif.softRst) |=>
    (readoutAbort && storeClear && frameCnt_reg == 3'h0))
    else $error("clear did not abort");
  wake_flush_a: assert property (
    (st == SEQ_PWRDN && !pdLvl && !rif.softRst) |=>
    (storeClear && st == SEQ_WAKE && pixelFlushActive))
    else $error("no flush on wake");
  pd_discard_a: assert property (
    st == SEQ_PWRDN |-> (frameCnt_reg == 3'h0 && powerDownActive))
    else $error("frames kept in power-down");
  pd_wait_a: assert property (
    (pdLvl && st != SEQ_PWRDN &&
     (readActive || st == SEQ_EXPOSE || st == SEQ_SHIFT)) |=>
    st != SEQ_PWRDN)
    else $error("power-down cut acquisition");
  temp_lock_a: assert property (
    (rdMask_reg != 4'h0 && tempValid) |=> $stable(tempL_reg))
    else $error("temperature updated while locked");
  ptr_step_a: assert property (
    (rif.wrStb && !rif.softRst) |=> ptr_reg == $past(ptr_reg) + 8'h1)
    else $error("pointer did not step");
  addr_prefix_a: assert property (
    addrLoad_reg == 2'h0 |-> devAddr_reg[6:4] == `CLSC_ADDR_PREFIX)
    else $error("address prefix wrong");
endmodule

// ===== rtl/clsc_params.svh
`ifndef CLSC_PARAMS_SVH
`define CLSC_PARAMS_SVH

// ********************************************************
// Timing
// ********************************************************
`define CLSC_CLK_NS 10
`define CLSC_SHIFT_CYCLES 25
`define CLSC_FLUSH_NS 1000

// ********************************************************
// Addressing and general call commands
// ********************************************************
`define CLSC_ADDR_PREFIX 3'h1
`define CLSC_GC_ADDR 8'h00
`define CLSC_GC_RESET 8'h06
`define CLSC_GC_RESAMPLE 8'h04

// ********************************************************
// Register offsets
// ********************************************************
`define CLSC_REG_ACQ 8'h00
`define CLSC_REG_BW 8'h01
`define CLSC_REG_MISC 8'h02
`define CLSC_REG_ACQ_EFF 8'h03
`define CLSC_REG_BW_EFF 8'h04
`define CLSC_REG_TRIM 8'h90
`define CLSC_REG_GBW 8'h94
`define CLSC_REG_TEMP_BASE 6'h28
`define CLSC_REG_TEMP_CONF 8'ha4
`define CLSC_REG_ERR 8'hb0

// ********************************************************
// Reset values and frame limit
// ********************************************************
`define CLSC_CONF_RST 8'h00
`define CLSC_TRIM_RST 8'h40
`define CLSC_MAX_FRAMES 3'h4

`endif

// ===== rtl/clsc_pkg.sv
package clsc_pkg;
  typedef logic [11:0] clsc_temp_t;
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_EXPFLUSH, SEQ_EXPOSE, SEQ_SHIFT, SEQ_IGNORE,
    SEQ_PWRDN, SEQ_WAKE
  } clsc_seq_e;
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_RX, I2C_RXACK, I2C_TX, I2C_TXACK
  } clsc_i2c_e;
endpackage

// ===== rtl/clsc_reg_if.sv
`timescale 1ns/10ps
interface clsc_reg_if;
  logic ptrLoad;
  logic wrStb;
  logic rdStb;
  logic softRst;
  logic resample;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [6:0] devAddr;
  modport slave(output ptrLoad, wrStb, rdStb, softRst, resample, wdata,
                input rdata, devAddr);
  modport regs(input ptrLoad, wrStb, rdStb, softRst, resample, wdata,
               output rdata, devAddr);
endinterface

// ===== rtl/clsc_i2c_slave.sv
`timescale 1ns/10ps
`include "clsc_params.svh"
module clsc_i2c_slave (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOe,
  clsc_reg_if.slave rif
);
  import clsc_pkg::*;

  // ********************************************************
  // Pin synchronisers, stage 2 vs 3 for edges
  // ********************************************************
  logic [2:0] sclS;
  logic [2:0] sdaS;
  logic sclRise, sclFall, startCond, stopCond;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sclS <= 3'h7;
      sdaS <= 3'h7;
    end else begin
      sclS <= {sclS[1:0], sclIn};
      sdaS <= {sdaS[1:0], sdaIn};
    end
  end

  assign sclRise = sclS[1] && !sclS[2];
  assign sclFall = !sclS[1] && sclS[2];
  assign startCond = sclS[1] && sclS[2] && !sdaS[1] && sdaS[2];
  assign stopCond = sclS[1] && sclS[2] && sdaS[1] && !sdaS[2];

  // ********************************************************
  // Byte engine
  // ********************************************************
  clsc_i2c_e st, stNext;
  logic [3:0] bitCnt_reg, bitCnt_next;
  logic [7:0] sh_reg, sh_next;
  logic first_reg, first_next, ptrPh_reg, ptrPh_next;
  logic gc_reg, gc_next, rw_reg, rw_next, oe_reg, oe_next;

  assign rif.wdata = sh_reg;
  assign sdaOe = oe_reg;

  always_comb begin
    stNext = st;
    bitCnt_next = bitCnt_reg;
    sh_next = sh_reg;
    first_next = first_reg;
    ptrPh_next = ptrPh_reg;
    gc_next = gc_reg;
    rw_next = rw_reg;
    oe_next = oe_reg;
    rif.ptrLoad = 1'b0;
    rif.wrStb = 1'b0;
    rif.rdStb = 1'b0;
    rif.softRst = 1'b0;
    rif.resample = 1'b0;
    if (stopCond) begin
      stNext = I2C_IDLE;
      oe_next = 1'b0;
    end else if (startCond) begin
      stNext = I2C_RX;
      bitCnt_next = 4'h0;
      first_next = 1'b1;
      gc_next = 1'b0;
      rw_next = 1'b0;
      oe_next = 1'b0;
    end else begin
      unique case (st)
        I2C_IDLE: begin
        end
        I2C_RX: begin
          if (sclRise) begin
            sh_next = {sh_reg[6:0], sdaS[1]};
            bitCnt_next = bitCnt_reg + 4'h1;
          end else if (sclFall && bitCnt_reg == 4'h8) begin
            stNext = I2C_RXACK;
            oe_next = 1'b1;
            first_next = 1'b0;
            if (first_reg) begin
              if (sh_reg[7:1] == rif.devAddr) begin
                rw_next = sh_reg[0];
                ptrPh_next = !sh_reg[0];
              end else if (sh_reg == `CLSC_GC_ADDR) begin
                gc_next = 1'b1;
              end else begin
                stNext = I2C_IDLE;
                oe_next = 1'b0;
              end
            end else if (gc_reg) begin
              rif.softRst = (sh_reg == `CLSC_GC_RESET);
              rif.resample = (sh_reg == `CLSC_GC_RESAMPLE);
            end else if (ptrPh_reg) begin
              rif.ptrLoad = 1'b1;
              ptrPh_next = 1'b0;
            end else begin
              // write lands on last bit fall
              rif.wrStb = 1'b1;
            end
          end
        end
        I2C_RXACK: begin
          if (sclFall) begin
            bitCnt_next = 4'h0;
            oe_next = 1'b0;
            if (rw_reg) begin
              stNext = I2C_TX;
              rif.rdStb = 1'b1;
              sh_next = rif.rdata;
              oe_next = !rif.rdata[7];
            end else begin
              stNext = I2C_RX;
            end
          end
        end
        I2C_TX: begin
          if (sclFall) begin
            bitCnt_next = bitCnt_reg + 4'h1;
            if (bitCnt_reg == 4'h7) begin
              stNext = I2C_TXACK;
              oe_next = 1'b0;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = !sh_reg[6];
            end
          end
        end
        I2C_TXACK: begin
          if (sclRise && sdaS[1]) begin
            stNext = I2C_IDLE;
          end else if (sclFall) begin
            stNext = I2C_TX;
            bitCnt_next = 4'h0;
            rif.rdStb = 1'b1;
            sh_next = rif.rdata;
            oe_next = !rif.rdata[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= I2C_IDLE;
      bitCnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      first_reg <= 1'b0;
      ptrPh_reg <= 1'b0;
      gc_reg <= 1'b0;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      st <= stNext;
      bitCnt_reg <= bitCnt_next;
      sh_reg <= sh_next;
      first_reg <= first_next;
      ptrPh_reg <= ptrPh_next;
      gc_reg <= gc_next;
      rw_reg <= rw_next;
      oe_reg <= oe_next;
    end
  end
endmodule

// ===== tb/clsc_i2c_master.sv
`timescale 1ns/10ps
// *****
// I2C master model
// *****
module clsc_i2c_master (
  input wire logic clk,
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  logic scl = 1'b1;
  logic sda = 1'b1;
  assign sclIn = scl;
  // Pull-up: a released line reads high
  assign sdaIn = sda & ~sdaOe;
  task automatic q();
    repeat (20) @(posedge clk);
    #1;
  endtask
  task automatic bitx(input logic b, output logic s);
    sda = b;
    q();
    scl = 1'b1;
    q();
    s = sdaIn;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic start();
    sda = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda = 1'b1;
    q();
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ackIn,
                      output logic [7:0] rx, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], s);
      rx[i] = s;
    end
    bitx(ackIn, s);
    ack = ~s;
  endtask
endmodule

// ===== tb/clsc_top_tb.sv
`timescale 1ns/10ps
// *****
// Bench
// *****
module clsc_top_tb;
  import clsc_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic gate = 0, pix = 0, clr = 0, pd = 0, rdAct = 0, tv = 0;
  logic [1:0] selA = 2'h1, selB = 2'h1;
  clsc_temp_t tL = '0, tR = '0, oL, oR;
  logic scl, sda, oe, sdo, pfa, stc, abt, fav, shf, exq, pda, ok;
  logic [7:0] acq, bw, misc, gbw, tcf, trim, d[$], r[$];
  logic [6:0] dev;
  int error_cnt = 0, n_compared = 0, clrCnt = 0, abtCnt = 0, n, b;
  always #5 clk = ~clk;
  // Pulses counted away from the edge that launches them
  always @(negedge clk) begin
    if (stc === 1'b1) clrCnt++;
    if (abt === 1'b1) abtCnt++;
  end
  clsc_top #(.FLUSH_NS(100)) clsc_top_inst (.clk(clk), .arst_n(arst_n),
    .exposureGate(gate), .pixelFlushPulse(pix), .frameClearPulse(clr),
    .powerDownPin(pd), .addressSelectA(selA), .addressSelectB(selB),
    .readActive(rdAct), .frameTaken(1'b0), .tempValid(tv), .tempLeft(tL),
    .tempRight(tR), .sclIn(scl), .sdaIn(sda), .sdaOut(sdo), .sdaOe(oe),
    .pixelFlushActive(pfa), .storeClear(stc), .readoutAbort(abt),
    .frameAvailable(fav), .shifting(shf), .exposing(exq),
    .powerDownActive(pda), .acqConf(acq), .bwConf(bw), .miscConf(misc),
    .oscTrim(trim), .gbwSel(gbw), .tempConf(tcf));
  clsc_i2c_master m (.clk(clk), .sdaOe(oe), .sclIn(scl), .sdaIn(sda));
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  function automatic logic [1:0] tern(input logic [1:0] p);
    return (p == 2'h0) ? 2'h0 : (p == 2'h1) ? 2'h1 : 2'h3;
  endfunction
  task automatic waitOn(input int k, output int c);
    c = 0;
    while ((k == 0 ? shf : k == 1 ? !shf : k == 2 ? pda : exq) !== 1'b1) begin
      cyc(1);
      c++;
      if (c == 300) begin
        error_cnt++;
        wrap_up();
      end
    end
  endtask
  task automatic wr(input logic [6:0] a);
    logic [7:0] x;
    logic k;
    m.start();
    m.xfer({a, 1'b0}, 1'b1, x, ok);
    foreach (d[i]) begin
      m.xfer(d[i], 1'b1, x, k);
      ok &= k;
    end
    m.stop();
  endtask
  task automatic rd(input logic [7:0] p, input int c);
    logic [7:0] x;
    logic k;
    r = {};
    m.start();
    m.xfer({dev, 1'b0}, 1'b1, x, k);
    m.xfer(p, 1'b1, x, k);
    m.start();
    m.xfer({dev, 1'b1}, 1'b1, x, k);
    for (int i = 0; i < c; i++) begin
      m.xfer(8'hff, i == c - 1, x, k);
      r.push_back(x);
    end
    m.stop();
  endtask
  task automatic acquire();
    gate = 1'b1;
    waitOn(3, n);
    pix = 1'b1;
    cyc(5);
    pix = 1'b0;
    chk("flushInGate", 16'h0, 16'(pfa));
    gate = 1'b0;
    waitOn(0, n);
    // Flush edge inside the shift interval
    pix = 1'b1;
    waitOn(1, n);
    pix = 1'b0;
    chk("flushInShift", 16'h0, 16'(pfa));
    chk("shiftLen", 16'h1, 16'(n inside {[24:26]}));
    chk("frameAvail", 16'h1, 16'(fav));
  endtask
  task automatic tpulse();
    tv = 1'b1;
    cyc(1);
    tv = 1'b0;
  endtask
  initial begin
    #600_000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    void'($urandom(94));
    cyc(20);
    arst_n = 1'b1;
    cyc(10);
    dev = {3'h1, tern(selB), tern(selA)};
    chk("trimRst", 16'h4040, 16'({trim, gbw}));
    chk("sdaOut", 16'h0, 16'(sdo));
    d = {8'h00, 8'($urandom), 8'($urandom), 8'($urandom)};
    wr(dev);
    chk("wrAck", 16'h1, 16'(ok));
    chk("acq", 16'(d[1]), 16'(acq));
    chk("bwMisc", 16'({d[2], d[3]}), 16'({bw, misc}));
    rd(8'h00, 3);
    chk("rd0", 16'(d[1]), 16'(r[0]));
    chk("rd2", 16'(d[3]), 16'(r[2]));
    d = {8'h50, 8'hff};
    wr(dev);
    chk("unmapped", 16'({1'b1, r[0]}), 16'({ok, acq}));
    wr(dev ^ {1'b1, 6'($urandom)});
    chk("otherAddr", 16'h0, 16'(ok));
    tL = 12'($urandom);
    tR = 12'($urandom);
    oL = tL;
    oR = tR;
    tpulse();
    rd(8'ha0, 1);
    tL = ~oL;
    tR = ~oR;
    tpulse();
    rd(8'ha1, 3);
    chk("tempLock", 16'({oL[11:8], oR}),
        16'({r[0][3:0], r[2][3:0], r[1]}));
    tpulse();
    rd(8'ha0, 1);
    chk("tempFree", 16'(tL[7:0]), 16'(r[0]));
    // Gap bytes land on unmapped offsets
    d = {8'h90, 8'h5a, 8'h11, 8'h22, 8'h33, 8'h3c};
    wr(dev);
    chk("trimGbw", 16'h5a3c, 16'({trim, gbw}));
    d = {8'ha4, 8'hc3};
    wr(dev);
    chk("tempConf", 16'hc3, 16'(tcf));
    d = {8'h06};
    wr(7'h00);
    cyc(5);
    chk("softRst", 16'h0040, 16'({acq, trim}));
    chk("softRst2", 16'h4000, 16'({gbw, tcf}));
    selA = 2'h2;
    selB = 2'h0;
    cyc(5);
    d = {8'h04};
    wr(7'h00);
    dev = {3'h1, tern(selB), tern(selA)};
    d = {8'h00, 8'h33};
    wr(dev);
    chk("resample", 16'h133, 16'({ok, acq}));
    pix = 1'b1;
    cyc(2);
    gate = 1'b1;
    cyc(3);
    chk("idleFlush", 16'h1, 16'(pfa));
    cyc(27);
    chk("gateInFlush", 16'h0, 16'(exq));
    gate = 1'b0;
    pix = 1'b0;
    cyc(40);
    acquire();
    // extra flush pulse in the idle gap
    pix = 1'b1;
    cyc(5);
    pix = 1'b0;
    cyc(20);
    acquire();
    b = clrCnt;
    n = abtCnt;
    clr = 1'b1;
    cyc(5);
    clr = 1'b0;
    cyc(5);
    chk("clear", 16'h0, 16'(fav));
    chk("clearPulse", 16'(b + 1), 16'(clrCnt));
    chk("abort", 16'(n + 1), 16'(abtCnt));
    acquire();
    rdAct = 1'b1;
    pd = 1'b1;
    cyc(10);
    chk("pdWait", 16'h0, 16'(pda));
    rdAct = 1'b0;
    waitOn(2, n);
    chk("pdDrop", 16'h0, 16'(fav));
    b = clrCnt;
    pd = 1'b0;
    cyc(20);
    chk("wakeFlush", 16'(b + 1), 16'(clrCnt));
    wrap_up();
  end
endmodule
